/* rtl/eeprom_pkg.sv */
`default_nettype none
package eeprom_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int WORDS = 128;
  localparam int ADDR_W = 7;
  localparam int MAX_WRITE_BYTES = 2;
  localparam logic [3:0] DEVICE_TYPE_RESET = 4'h5;
  localparam int EW_MS_PER_WORD = 30;
  localparam int EW_MIN_MS = 20;
  localparam int EW_MAX_MS = 100;
  localparam int EW_CYCLES_PER_WORD = CLK_HZ / 1000 * EW_MS_PER_WORD;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;
endpackage
`default_nettype wire

/* rtl/eeprom_slave.sv */
`default_nettype none
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_RESET,
  parameter int EW_CYCLES = EW_CYCLES_PER_WORD
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CLK_EN,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  input wire logic I_CHIP_SEL_BIT0,
  input wire logic I_CHIP_SEL_BIT1,
  input wire logic I_CHIP_SEL_BIT2,
  input wire logic I_CYCLE_TIMING_NETWORK_INPUT,
  output logic O_BUSY
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_DEV = 6'b000010,
    S_WADDR = 6'b000100,
    S_WDATA = 6'b001000,
    S_RDATA = 6'b010000,
    S_IGNORE = 6'b100000
  } state_e;

  logic [1:0] scl_s_q, sda_s_q, chs_s_q;
  logic [2:0] cs0_q, cs1_q, cs2_q;
  logic scl_q, sda_q;
  logic [7:0] mem [WORDS];

  state_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic ack_q, ack_d;
  logic sda_oe_q, sda_oe_d;
  logic rd_ack_q, rd_ack_d;
  logic [1:0] nb_q, nb_d;
  logic [ADDR_W-1:0] wa0_q, wa0_d, wa1_q, wa1_d;
  logic [7:0] wd0_q, wd0_d, wd1_q, wd1_d;
  logic [31:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic [1:0] pend_q, pend_d;
  logic pend_hold_q;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, addr_hit;

  // Bus lines and timing input pass two flops, strap pins three
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      chs_s_q <= 2'h0;
      cs0_q <= 3'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (I_CLK_EN) begin
      scl_s_q <= {scl_s_q[0], I_SCL};
      sda_s_q <= {sda_s_q[0], I_SDA};
      chs_s_q <= {chs_s_q[0], I_CYCLE_TIMING_NETWORK_INPUT};
      cs0_q <= {cs0_q[1:0], I_CHIP_SEL_BIT0};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end

  // Straps are static, the extra flop only costs latency
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cs1_q <= 3'h0;
      cs2_q <= 3'h0;
    end else if (I_CLK_EN) begin
      cs1_q <= {cs1_q[1:0], I_CHIP_SEL_BIT1};
      cs2_q <= {cs2_q[1:0], I_CHIP_SEL_BIT2};
    end
  end

  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c = scl & scl_q & ~sda_q & sda;
  // Address match on bits 7:1 of the shifted byte
  assign addr_hit = (sh_q[7:4] == DEVICE_TYPE)
    && (sh_q[3:1] == {cs2_q[2], cs1_q[2], cs0_q[2]})
    && !busy_q;

  // Bits shift on SCL rise; SDA drive moves after SCL fall
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ack_d = ack_q;
    sda_oe_d = sda_oe_q;
    rd_ack_d = rd_ack_q;
    nb_d = nb_q;
    wa0_d = wa0_q;
    wa1_d = wa1_q;
    wd0_d = wd0_q;
    wd1_d = wd1_q;
    pend_d = pend_q;
    if (start_c) begin
      st_d = S_DEV;
      bit_d = 4'h0;
      ack_d = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = S_IDLE;
      sda_oe_d = 1'b0;
      ack_d = 1'b0;
      if (nb_q != 2'h0) begin
        pend_d = nb_q;
      end
      nb_d = 2'h0;
    end else if (st_q != S_IDLE && st_q != S_IGNORE) begin
      if (scl_rise) begin
        if (bit_q < 4'h8) begin
          sh_d = {sh_q[6:0], sda};
          bit_d = bit_q + 4'h1;
        end else if (ack_q && st_q == S_RDATA) begin
          rd_ack_d = ~sda;
        end
      end else if (scl_fall) begin
        if (bit_q == 4'h8 && !ack_q) begin
          ack_d = 1'b1;
          unique case (st_q)
            S_DEV: begin
              if (addr_hit) begin
                sda_oe_d = 1'b1;
                st_d = sh_q[0] ? S_RDATA : S_WADDR;
              end else begin
                st_d = S_IGNORE;
              end
            end
            S_WADDR: begin
              ptr_d = sh_q[ADDR_W-1:0];
              sda_oe_d = 1'b1;
              st_d = S_WDATA;
            end
            S_WDATA: begin
              // Slots full: byte dropped, no acknowledge
              if (nb_q < 2'(MAX_WRITE_BYTES)) begin
                if (nb_q == 2'h0) begin
                  wa0_d = ptr_q;
                  wd0_d = sh_q;
                end else begin
                  wa1_d = ptr_q;
                  wd1_d = sh_q;
                end
                ptr_d = ptr_q + ADDR_W'(1);
                nb_d = nb_q + 2'h1;
                sda_oe_d = 1'b1;
              end
            end
            S_RDATA: begin
              sda_oe_d = 1'b0;
            end
            default: begin
            end
          endcase
        end else if (bit_q == 4'h8 && ack_q) begin
          // Acknowledge slot over, set up next byte
          bit_d = 4'h0;
          ack_d = 1'b0;
          sda_oe_d = 1'b0;
          if (st_q == S_RDATA) begin
            if (sda_oe_q) begin
              // Own address acknowledge over: first byte, pointer kept
              sda_oe_d = ~sh_q[7];
            end else if (rd_ack_q) begin
              ptr_d = ptr_q + ADDR_W'(1);
              sh_d = mem[ptr_q + ADDR_W'(1)];
              sda_oe_d = ~mem[ptr_q + ADDR_W'(1)][7];
            end else begin
              st_d = S_IGNORE;
            end
            rd_ack_d = 1'b0;
          end
        end else if (st_q == S_RDATA && bit_q < 4'h8) begin
          sda_oe_d = ~sh_q[7]; // Register shifts each rise, bit 7 is next
        end
      end
      if (scl_fall && st_q == S_DEV && bit_q == 4'h8 && !ack_q && addr_hit && sh_q[0]) begin
        sh_d = mem[ptr_q];
        rd_ack_d = 1'b1;
      end
      if (st_q == S_RDATA && bit_q == 4'h8 && ack_q && scl_rise) begin
        rd_ack_d = ~sda;
      end
    end
  end

  // Self-timed erase/write; network input halts the timer while low
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (!busy_q && pend_q != 2'h0 && st_q == S_IDLE) begin
      busy_d = 1'b1;
      cnt_d = (pend_q == 2'h2) ? 32'(2 * EW_CYCLES) : 32'(EW_CYCLES);
    end else if (busy_q && chs_s_q[1]) begin
      if (cnt_q <= 32'h0000_0001) begin
        busy_d = 1'b0;
        cnt_d = 32'h0000_0000;
      end else begin
        cnt_d = cnt_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= '0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rd_ack_q <= 1'b0;
      nb_q <= 2'h0;
      wa0_q <= '0;
      wa1_q <= '0;
      wd0_q <= 8'h00;
      wd1_q <= 8'h00;
      cnt_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      pend_q <= 2'h0;
    end else if (I_CLK_EN) begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ack_q <= ack_d;
      sda_oe_q <= sda_oe_d;
      rd_ack_q <= rd_ack_d;
      nb_q <= nb_d;
      wa0_q <= wa0_d;
      wa1_q <= wa1_d;
      wd0_q <= wd0_d;
      wd1_q <= wd1_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      pend_q <= (busy_d && !busy_q) ? 2'h0 : pend_d;
    end
  end

  // Memory commits the latched bytes when the cycle ends
  always_ff @(posedge I_MCLK) begin
    if (I_CLK_EN && busy_q && !busy_d) begin
      mem[wa0_q] <= wd0_q;
      if (pend_hold_q) begin
        mem[wa1_q] <= wd1_q;
      end
    end
  end

  // Second byte slot must be committed too
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_hold_q <= 1'b0;
    end else if (I_CLK_EN && busy_d && !busy_q) begin
      pend_hold_q <= (pend_q == 2'h2);
    end
  end

  // Open drain: only the enable toggles
  assign O_SDA = 1'b0;
  assign O_SDA_OE = sda_oe_q;
  assign O_BUSY = busy_q;
endmodule
`default_nettype wire

/* tb/eeprom_master_model.sv */
`default_nettype none
module eeprom_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only while SCL is low; equal phases, time scaled
  task automatic clk(input logic v, output logic s);
    sda_low = !v;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 0;
    #40;
  endtask
  // First or repeated START
  task automatic start();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask
  // STOP, then the bus is left idle
  task automatic stop();
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #400;
  endtask
  // Ninth clock; last read byte gets no ack
  task automatic xfer(input logic [7:0] o, input logic last, output logic [7:0] i,
                      output logic ack);
    for (int k = 7; k >= 0; k--) clk(o[k], i[k]);
    clk(last, ack);
    ack = !ack;
  endtask
endmodule
`default_nettype wire

/* tb/eeprom_slave_properties.sv */
`default_nettype none
module eeprom_slave_checker #(
  parameter int EW_CYCLES = 200
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic I_CYCLE_TIMING_NETWORK_INPUT,
  input wire logic O_BUSY
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  logic [7:0] since_stop_q, since_stop_d;
  logic [31:0] busy_len_q, busy_len_d;
  logic sda_q;
  always_comb begin
    since_stop_d = since_stop_q + {7'h0, since_stop_q != 8'hFF};
    if (I_SCL && I_SDA && !sda_q) begin
      since_stop_d = 8'h0;
    end
    // Timer stalls while the network input is low
    busy_len_d = O_BUSY ? busy_len_q + {31'h0, I_CYCLE_TIMING_NETWORK_INPUT} : 32'h0;
  end
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      since_stop_q <= 8'hFF;
      busy_len_q <= 32'h0;
      sda_q <= 1'b1;
    end else begin
      since_stop_q <= since_stop_d;
      busy_len_q <= busy_len_d;
      sda_q <= I_SDA;
    end
  end
  open_drain_a: assert property (O_SDA == 1'b0)
    else $error("sda data not low");
  ack_width_a: assert property ($rose(O_SDA_OE) |-> O_SDA_OE[*6])
    else $error("drive too short");
  scl_high_stable_a: assert property (
    I_SCL && $past(I_SCL) && $past(I_SCL, 2) |-> $stable(O_SDA_OE))
    else $error("sda moved under scl high");
  drive_on_low_a: assert property ($rose(O_SDA_OE) |-> !$past(I_SCL, 2))
    else $error("drive began with scl high");
  idle_release_a: assert property (I_SCL[*6] |-> !O_SDA_OE)
    else $error("sda held while idle");
  busy_quiet_a: assert property (O_BUSY |-> !O_SDA_OE)
    else $error("ack while busy");
  busy_after_stop_a: assert property ($rose(O_BUSY) |-> since_stop_q < 8'h20)
    else $error("busy without stop");
  busy_length_a: assert property (
    $fell(O_BUSY) |-> busy_len_q >= EW_CYCLES - 1 && busy_len_q <= 2 * EW_CYCLES + 1)
    else $error("busy length wrong");
  cover property ($rose(O_BUSY));
  cover property ($fell(O_BUSY));
  cover property ($rose(O_SDA_OE));
endmodule
bind eeprom_slave eeprom_slave_checker #(.EW_CYCLES(EW_CYCLES)) chk (.I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
  .I_CYCLE_TIMING_NETWORK_INPUT(I_CYCLE_TIMING_NETWORK_INPUT), .O_BUSY(O_BUSY));
`default_nettype wire

/* tb/eeprom_slave_bench.sv */
`default_nettype none
module eeprom_slave_bench import eeprom_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EW = 200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cs = 3'h5;
  logic net_run = 1'b1;
  logic scl, sda_low, oe, sdo, busy, a;
  logic [7:0] d;
  int miscompares = 0;
  int cmp_count = 0;
  wire logic sda = !(sda_low || (oe && !sdo));
  always #10 clk = !clk;
  eeprom_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));
  eeprom_slave #(.EW_CYCLES(EW)) uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1),
    .I_SCL(scl), .I_SDA(sda), .O_SDA(sdo), .O_SDA_OE(oe), .I_CHIP_SEL_BIT0(cs[0]),
    .I_CHIP_SEL_BIT1(cs[1]), .I_CHIP_SEL_BIT2(cs[2]), .I_CYCLE_TIMING_NETWORK_INPUT(net_run),
    .O_BUSY(busy));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] sa(input logic rw, input logic [2:0] c);
    return {DEVICE_TYPE_RESET, c, rw};
  endfunction
  task automatic wr(input logic [7:0] o, input logic exp);
    m.xfer(o, 1'b1, d, a);
    check("ack", {7'h0, a}, {7'h0, exp});
  endtask
  task automatic rd(input logic last, input logic [7:0] exp);
    m.xfer(8'hFF, last, d, a);
    check("data", d, exp);
  endtask
  task automatic t_write_wrap();
    m.start();
    wr(sa(1'b0, cs), 1'b1);
    wr(8'h7F, 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h3C, 1'b1);
    m.stop();
    check("busy", {7'h0, busy}, 8'h1);
    m.start();
    wr(sa(1'b0, cs), 1'b0);
    m.stop();
    @(posedge clk);
    net_run <= 1'b0;
    repeat (2 * EW) @(posedge clk);
    check("busy", {7'h0, busy}, 8'h1);
    net_run <= 1'b1;
    repeat (2 * EW + 50) @(posedge clk);
    #7;
    check("busy", {7'h0, busy}, 8'h0);
    $display("t_write_wrap done");
  endtask
  task automatic t_read_seq();
    m.start();
    wr(sa(1'b0, cs), 1'b1);
    wr(8'h7F, 1'b1);
    m.start();
    wr(sa(1'b1, cs), 1'b1);
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'h3C);
    m.stop();
    m.start();
    wr(sa(1'b1, cs), 1'b1);
    rd(1'b1, 8'h3C);
    m.stop();
    $display("t_read_seq done");
  endtask
  task automatic t_refuse();
    m.start();
    wr(sa(1'b0, cs ^ 3'h1), 1'b0);
    m.stop();
    m.start();
    wr(sa(1'b0, cs), 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b0);
    m.stop();
    repeat (2 * EW + 50) @(posedge clk);
    #7;
    m.start();
    wr(sa(1'b0, cs), 1'b1);
    wr(8'h10, 1'b1);
    m.start();
    wr(sa(1'b1, cs), 1'b1);
    rd(1'b0, 8'h11);
    rd(1'b1, 8'h22);
    m.stop();
    $display("t_refuse done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #7;
    t_write_wrap();
    t_read_seq();
    t_refuse();
    give_verdict();
  end
endmodule
`default_nettype wire
